// >>> rtl/pm_sfr_pkg.sv
package pm_sfr_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_POWER_CONTROL     = 8'hC5;
    localparam logic [7:0] OFS_POWER_IRQ_ENABLE  = 8'hEC;
    localparam logic [7:0] OFS_PERIPHERAL_CONFIG = 8'hF4;
    localparam logic [7:0] OFS_SWITCHOVER_CONFIG = 8'hF5;
    localparam logic [7:0] OFS_POWER_IRQ_FLAGS   = 8'hF8;
    localparam logic [7:0] OFS_SCRATCH_PAD_1     = 8'hFB;
    localparam logic [7:0] OFS_SCRATCH_PAD_2     = 8'hFC;
    localparam logic [7:0] OFS_SCRATCH_PAD_3     = 8'hFD;
    localparam logic [7:0] OFS_SCRATCH_PAD_4     = 8'hFE;
    localparam logic [7:0] OFS_IRQ_PIN_CONFIG    = 8'hFF;
    localparam logic [7:0] OFS_UNLOCK_KEY        = 8'hC1;

    // ----------------------------------------
    // Values and field positions
    // ----------------------------------------
    localparam logic [7:0] UNLOCK_VALUE     = 8'hEA;
    localparam logic [7:0] RESET_ZERO       = 8'h00;
    localparam logic [7:0] PERIPHERAL_CONFIG_RESET     = 8'h60;
    localparam logic [7:0] PERIPHERAL_CONFIG_WR_MASK   = 8'h0F;
    localparam int         CAL_EN_BIT       = 7;
    localparam int         FSEL_LSB         = 5;
    localparam int         INT1_LSB         = 1;
    localparam int         INT0_BIT         = 0;
    localparam int         SRC_BIT          = 6;
    localparam int         F_RESTORED       = 7;
    localparam int         F_SUMMARY        = 6;
    localparam int         F_SAG            = 5;
    localparam int         F_ADC            = 3;
    localparam int         F_BAT            = 2;
    localparam int         F_SWITCH         = 1;
    localparam int         F_DCLOW          = 0;
    localparam logic [7:0] IRQ_EN_MASK      = 8'hAF;
    localparam logic [7:0] POLICY_MASK      = 8'h03;

    // ----------------------------------------
    // Calibration half periods in 10 ns cycles
    // ----------------------------------------
    localparam int         CLK_HZ           = 100_000_000;
    localparam int         CAL_HZ_0         = 1;
    localparam int         CAL_HZ_1         = 512;
    localparam int         CAL_HZ_2         = 500;
    localparam int         CAL_HZ_3         = 16384;
    localparam logic [31:0] HALF_0 = 32'(CLK_HZ / (2 * CAL_HZ_0));
    localparam logic [31:0] HALF_1 = 32'(CLK_HZ / (2 * CAL_HZ_1));
    localparam logic [31:0] HALF_2 = 32'(CLK_HZ / (2 * CAL_HZ_2));
    localparam logic [31:0] HALF_3 = 32'(CLK_HZ / (2 * CAL_HZ_3));

    typedef enum logic [1:0] {
        POL_LOW_VDD    = 2'b00,
        POL_LOW_VDD_DC = 2'b01,
        POL_OFF_A      = 2'b10,
        POL_OFF_B      = 2'b11
    } policy_t;
endpackage

// >>> rtl/power_mgmt_sfr_bank.sv
`timescale 1ns/1ps
module power_mgmt_sfr_bank
    import pm_sfr_pkg::*;
(
    input  wire logic       SYS_CLK,
    input  wire logic       RSTN,
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic [7:0] SFR_WDATA,
    input  wire logic       SFR_WR,
    input  wire logic       SFR_RD,
    output logic      [7:0] SFR_RDATA,
    input  wire logic       MAIN_SUPPLY_LOW,
    input  wire logic       DC_INPUT_LOW,
    input  wire logic       SAG_EVENT,
    input  wire logic       DC_DELTA_EVENT,
    input  wire logic       DC_READY_EVENT,
    input  wire logic       BAT_LOW_EVENT,
    input  wire logic       BAT_READY_EVENT,
    output logic            CAL_OUT,
    output logic            CAL_OUT_ENABLE,
    output logic            EXT_IRQ1_GPIO,
    output logic            BATTERY_CONTROL_INPUT,
    output logic            EXT_IRQ1_ENABLE,
    output logic            EXT_IRQ0_ENABLE,
    output logic            USE_BATTERY,
    output logic            POWER_IRQ
);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [7:0]  ctrl_q, ctrl_d;
    logic [7:0]  ien_q, ien_d;
    logic [7:0]  peripheral_config_q, peripheral_config_d;
    logic [7:0]  swcfg_q, swcfg_d;
    logic [7:0]  flags_q, flags_d;
    logic [7:0]  pad_q [4], pad_d [4];
    logic [7:0]  pincfg_q, pincfg_d;
    logic [7:0]  key_q, key_d;
    logic        bat_q, bat_d;
    logic [7:0]  rdata_q, rdata_d;
    logic [31:0] cal_cnt_q, cal_cnt_d;
    logic        cal_q, cal_d;
    logic [31:0] half;
    logic        want_bat;
    logic [7:0]  events;
    policy_t     policy;
    logic        cal_out_d;
    logic        cal_oe_d;
    logic        irq1_gpio_d;
    logic        bat_ctrl_d;
    logic        irq1_en_d;
    logic        irq0_en_d;
    logic        power_irq_d;

    localparam int         PAD_COUNT    = 4;
    localparam logic [7:0] PAD_ADDR [4] = '{OFS_SCRATCH_PAD_1, OFS_SCRATCH_PAD_2,
                                            OFS_SCRATCH_PAD_3, OFS_SCRATCH_PAD_4};

    assign policy = policy_t'(swcfg_q[1:0]);

    // ----------------------------------------
    // Switchover policy
    // ----------------------------------------
    always_comb begin
        unique case (policy)
            POL_LOW_VDD:    want_bat = MAIN_SUPPLY_LOW;
            POL_LOW_VDD_DC: want_bat = MAIN_SUPPLY_LOW | DC_INPUT_LOW;
            POL_OFF_A,
            POL_OFF_B:      want_bat = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Configuration writes
    // ----------------------------------------
    always_comb begin
        ctrl_d   = ctrl_q;
        ien_d    = ien_q;
        swcfg_d  = swcfg_q;
        pincfg_d = pincfg_q;
        key_d    = key_q;
        if (SFR_WR) begin
            unique case (SFR_ADDR)
                OFS_POWER_CONTROL:     ctrl_d   = SFR_WDATA;
                OFS_POWER_IRQ_ENABLE:  ien_d    = SFR_WDATA;
                OFS_SWITCHOVER_CONFIG: swcfg_d  = SFR_WDATA & POLICY_MASK;
                OFS_IRQ_PIN_CONFIG: begin
                    if (key_q == UNLOCK_VALUE) begin
                        pincfg_d = SFR_WDATA;
                    end
                end
                OFS_UNLOCK_KEY:        key_d    = SFR_WDATA;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Status flags and supply source
    // ----------------------------------------
    always_comb begin
        bat_d    = want_bat;
        flags_d  = flags_q;
        peripheral_config_d = peripheral_config_q;
        events   = RESET_ZERO;
        events[F_RESTORED] = bat_q & ~want_bat;
        events[F_SAG]      = SAG_EVENT;
        events[F_ADC]      = DC_DELTA_EVENT | DC_READY_EVENT;
        events[F_BAT]      = BAT_LOW_EVENT | BAT_READY_EVENT;
        events[F_SWITCH]   = ~bat_q & want_bat;
        events[F_DCLOW]    = DC_INPUT_LOW;
        events[F_SUMMARY]  = |(events & ien_q & IRQ_EN_MASK);
        if (SFR_WR && (SFR_ADDR == OFS_POWER_IRQ_FLAGS)) begin
            flags_d = flags_q & SFR_WDATA;
        end
        if (SFR_WR && (SFR_ADDR == OFS_PERIPHERAL_CONFIG)) begin
            peripheral_config_d = (peripheral_config_q & ~PERIPHERAL_CONFIG_WR_MASK) | (SFR_WDATA & PERIPHERAL_CONFIG_WR_MASK);
        end
        // Set wins over a clearing write
        flags_d = flags_d | events;
        peripheral_config_d[SRC_BIT] = ~want_bat;
    end

    // ----------------------------------------
    // Scratch pads
    // ----------------------------------------
    for (genvar p = 0; p < PAD_COUNT; p++) begin : g_pad
        always_comb begin
            pad_d[p] = pad_q[p];
            if (SFR_WR && (SFR_ADDR == PAD_ADDR[p])) begin
                pad_d[p] = SFR_WDATA;
            end
        end
        always_ff @(posedge SYS_CLK or negedge RSTN) begin
            if (!RSTN) begin
                pad_q[p] <= RESET_ZERO;
            end else begin
                pad_q[p] <= pad_d[p];
            end
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb begin
        rdata_d = rdata_q;
        if (SFR_RD) begin
            unique case (SFR_ADDR)
                OFS_POWER_CONTROL:     rdata_d = ctrl_q;
                OFS_POWER_IRQ_ENABLE:  rdata_d = ien_q;
                OFS_PERIPHERAL_CONFIG: rdata_d = peripheral_config_q;
                OFS_SWITCHOVER_CONFIG: rdata_d = swcfg_q;
                OFS_POWER_IRQ_FLAGS:   rdata_d = flags_q;
                OFS_SCRATCH_PAD_1:     rdata_d = pad_q[0];
                OFS_SCRATCH_PAD_2:     rdata_d = pad_q[1];
                OFS_SCRATCH_PAD_3:     rdata_d = pad_q[2];
                OFS_SCRATCH_PAD_4:     rdata_d = pad_q[3];
                OFS_IRQ_PIN_CONFIG:    rdata_d = pincfg_q;
                OFS_UNLOCK_KEY:        rdata_d = key_q;
                default:               rdata_d = RESET_ZERO;
            endcase
        end
    end

    // ----------------------------------------
    // Calibration clock divider
    // ----------------------------------------
    always_comb begin
        unique case (pincfg_q[FSEL_LSB +: 2])
            2'b00: half = HALF_0;
            2'b01: half = HALF_1;
            2'b10: half = HALF_2;
            2'b11: half = HALF_3;
        endcase
        cal_cnt_d = cal_cnt_q + 32'h00000001;
        cal_d     = cal_q;
        if (!pincfg_q[CAL_EN_BIT]) begin
            cal_cnt_d = 32'h00000000;
            cal_d     = 1'b0;
        end else if (cal_cnt_d >= half) begin
            cal_cnt_d = 32'h00000000;
            cal_d     = ~cal_q;
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_q    <= RESET_ZERO;
            ien_q     <= RESET_ZERO;
            swcfg_q   <= RESET_ZERO;
            pincfg_q  <= RESET_ZERO;
            key_q     <= RESET_ZERO;
        end else begin
            ctrl_q    <= ctrl_d;
            ien_q     <= ien_d;
            swcfg_q   <= swcfg_d;
            pincfg_q  <= pincfg_d;
            key_q     <= key_d;
        end
    end

    // ----------------------------------------
    // Status registers
    // ----------------------------------------
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            peripheral_config_q  <= PERIPHERAL_CONFIG_RESET;
            flags_q   <= RESET_ZERO;
            bat_q     <= 1'b0;
        end else begin
            peripheral_config_q  <= peripheral_config_d;
            flags_q   <= flags_d;
            bat_q     <= bat_d;
        end
    end

    // ----------------------------------------
    // Read data register
    // ----------------------------------------
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rdata_q   <= RESET_ZERO;
        end else begin
            rdata_q   <= rdata_d;
        end
    end

    // ----------------------------------------
    // Calibration registers
    // ----------------------------------------
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cal_cnt_q <= 32'h00000000;
            cal_q     <= 1'b0;
        end else begin
            cal_cnt_q <= cal_cnt_d;
            cal_q     <= cal_d;
        end
    end

    // ----------------------------------------
    // Output next values
    // ----------------------------------------
    always_comb begin
        cal_out_d   = cal_d & pincfg_q[CAL_EN_BIT];
        cal_oe_d    = pincfg_d[CAL_EN_BIT];
        irq1_gpio_d = pincfg_d[INT1_LSB +: 2] == 2'b00;
        bat_ctrl_d  = pincfg_d[INT1_LSB +: 2] == 2'b01;
        irq1_en_d   = pincfg_d[INT1_LSB + 1 +: 2] == 2'b11;
        irq0_en_d   = pincfg_d[INT0_BIT];
        power_irq_d = flags_d[F_SUMMARY];
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            SFR_RDATA             <= RESET_ZERO;
            CAL_OUT               <= 1'b0;
            CAL_OUT_ENABLE        <= 1'b0;
            EXT_IRQ1_GPIO         <= 1'b1;
            BATTERY_CONTROL_INPUT <= 1'b0;
            EXT_IRQ1_ENABLE       <= 1'b0;
            EXT_IRQ0_ENABLE       <= 1'b0;
            USE_BATTERY           <= 1'b0;
            POWER_IRQ             <= 1'b0;
        end else begin
            SFR_RDATA             <= rdata_d;
            CAL_OUT               <= cal_out_d;
            CAL_OUT_ENABLE        <= cal_oe_d;
            EXT_IRQ1_GPIO         <= irq1_gpio_d;
            BATTERY_CONTROL_INPUT <= bat_ctrl_d;
            EXT_IRQ1_ENABLE       <= irq1_en_d;
            EXT_IRQ0_ENABLE       <= irq0_en_d;
            USE_BATTERY           <= bat_d;
            POWER_IRQ             <= power_irq_d;
        end
    end

endmodule

// >>> bench/pm_bank_properties.sv
`timescale 1ns/1ps
module pm_bank_properties
    import pm_sfr_pkg::*;
(
    input wire logic       SYS_CLK,
    input wire logic       RSTN,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic       SFR_WR,
    input wire logic       SFR_RD,
    input wire logic [7:0] SFR_RDATA,
    input wire logic       MAIN_SUPPLY_LOW,
    input wire logic       SAG_EVENT,
    input wire logic       CAL_OUT,
    input wire logic       CAL_OUT_ENABLE,
    input wire logic       EXT_IRQ1_GPIO,
    input wire logic       BATTERY_CONTROL_INPUT,
    input wire logic       EXT_IRQ1_ENABLE,
    input wire logic       EXT_IRQ0_ENABLE,
    input wire logic       USE_BATTERY,
    input wire logic       POWER_IRQ
);
    // ------------------------------
    // Shadow of key, enables, policy
    // ------------------------------
    logic [7:0] key_d, key_q, en_d, en_q;
    logic       off_d, off_q;
    wire  [4:0] pins = {CAL_OUT_ENABLE, EXT_IRQ1_GPIO, BATTERY_CONTROL_INPUT,
                        EXT_IRQ1_ENABLE, EXT_IRQ0_ENABLE};
    always_comb begin
        key_d = key_q;
        en_d = en_q;
        off_d = off_q;
        if (SFR_WR && SFR_ADDR == OFS_UNLOCK_KEY) key_d = SFR_WDATA;
        if (SFR_WR && SFR_ADDR == OFS_POWER_IRQ_ENABLE) en_d = SFR_WDATA;
        if (SFR_WR && SFR_ADDR == OFS_SWITCHOVER_CONFIG) off_d = SFR_WDATA[1];
    end
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            {key_q, en_q, off_q} <= 17'h0;
        end else begin
            {key_q, en_q, off_q} <= {key_d, en_d, off_d};
        end
    end
    default clocking dc @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    sequence pin_open;
        SFR_WR && SFR_ADDR == OFS_IRQ_PIN_CONFIG && key_q == UNLOCK_VALUE;
    endsequence
    sequence pin_shut;
        SFR_WR && SFR_ADDR == OFS_IRQ_PIN_CONFIG && key_q != UNLOCK_VALUE;
    endsequence
    a_pin_locked: assert property (pin_shut |=> $stable(pins))
        else $error("Locked pin write changed outputs");
    a_cal_enable: assert property (pin_open |=> CAL_OUT_ENABLE == $past(SFR_WDATA[7]))
        else $error("Calibration enable not taken");
    a_irq_decode: assert property (pin_open |=> pins[3:0] == {
        $past(SFR_WDATA[2:1]) == 2'b00, $past(SFR_WDATA[2:1]) == 2'b01,
        $past(SFR_WDATA[3:2]) == 2'b11, $past(SFR_WDATA[0])})
        else $error("Pin function decode wrong");
    a_cal_quiet: assert property (!CAL_OUT_ENABLE [*2] |-> !CAL_OUT)
        else $error("Calibration output active while disabled");
    a_sag_summary: assert property (SAG_EVENT && en_q[F_SAG] |=> POWER_IRQ)
        else $error("Enabled sag gave no interrupt");
    a_irq_hold: assert property (POWER_IRQ && !SFR_WR |=> POWER_IRQ)
        else $error("Interrupt dropped without clear");
    a_switch_on: assert property (MAIN_SUPPLY_LOW && !off_q && !SFR_WR |=> USE_BATTERY)
        else $error("No switchover on low main supply");
    a_unmapped_read: assert property (SFR_RD && SFR_ADDR < 8'hC1 |=> SFR_RDATA == 8'h00)
        else $error("Unmapped read not zero");
endmodule
bind power_mgmt_sfr_bank pm_bank_properties chk_i (.SYS_CLK, .RSTN, .SFR_ADDR, .SFR_WDATA,
    .SFR_WR, .SFR_RD, .SFR_RDATA, .MAIN_SUPPLY_LOW, .SAG_EVENT, .CAL_OUT, .CAL_OUT_ENABLE,
    .EXT_IRQ1_GPIO, .BATTERY_CONTROL_INPUT, .EXT_IRQ1_ENABLE, .EXT_IRQ0_ENABLE,
    .USE_BATTERY, .POWER_IRQ);

// >>> bench/pm_core_model.sv
`timescale 1ns/1ps
module pm_core_model
    import pm_sfr_pkg::*;
(
    input  wire logic       clk,
    output logic      [7:0] addr,
    output logic      [7:0] wdata,
    output logic            wr,
    output logic            rd
);
    initial begin
        {addr, wdata, wr, rd} = 18'h0;
    end
    // ------------------------------
    // One-cycle bus cycles, idle lines inverted
    // ------------------------------
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        if (a == OFS_POWER_IRQ_FLAGS) d[4] = 1'b0;
        if (a == OFS_SWITCHOVER_CONFIG) d[7:2] = 6'h00;
        @(negedge clk);
        {addr, wdata, wr} = {a, d, 1'b1};
        @(negedge clk);
        {addr, wdata, wr} = {~a, ~d, 1'b0};
    endtask
    task automatic get(input logic [7:0] a);
        @(negedge clk);
        {addr, rd} = {a, 1'b1};
        @(negedge clk);
        {addr, rd} = {~a, 1'b0};
    endtask
    task automatic put_key(input logic [7:0] d);
        put(OFS_UNLOCK_KEY, UNLOCK_VALUE);
        put(OFS_IRQ_PIN_CONFIG, d);
        put(OFS_UNLOCK_KEY, RESET_ZERO);
    endtask
endmodule

// >>> bench/power_mgmt_sfr_bank_test.sv
`timescale 1ns/1ps
module power_mgmt_sfr_bank_test;
    import pm_sfr_pkg::*;
    logic       clk = 1'b0, rstn = 1'b0, msl = 1'b0, dcl = 1'b0, rd_pend = 1'b0;
    logic       wr, rd, cal, cal_en, gpio, bci, i1en, i0en, bat, irq;
    logic [4:0] ev = 5'h00;
    logic [7:0] addr, wdata, rdata, exp_q[$];
    logic [7:0] ofs[11] = '{8'hC5, 8'hEC, 8'hF4, 8'hF5, 8'hF8, 8'hFB, 8'hFC, 8'hFD, 8'hFE,
                            8'hFF, 8'h00};
    logic [7:0] fl[5] = '{8'h60, 8'h08, 8'h08, 8'h04, 8'h04};
    int         err_total = 0, checks_done = 0, cyc = 0, seed = 71530, n;
    always #5 clk = ~clk;
    pm_core_model core (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
    power_mgmt_sfr_bank dut (.SYS_CLK(clk), .RSTN(rstn), .SFR_ADDR(addr), .SFR_WDATA(wdata),
        .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .MAIN_SUPPLY_LOW(msl),
        .DC_INPUT_LOW(dcl), .SAG_EVENT(ev[0]), .DC_DELTA_EVENT(ev[1]), .DC_READY_EVENT(ev[2]),
        .BAT_LOW_EVENT(ev[3]), .BAT_READY_EVENT(ev[4]), .CAL_OUT(cal), .CAL_OUT_ENABLE(cal_en),
        .EXT_IRQ1_GPIO(gpio), .BATTERY_CONTROL_INPUT(bci), .EXT_IRQ1_ENABLE(i1en),
        .EXT_IRQ0_ENABLE(i0en), .USE_BATTERY(bat), .POWER_IRQ(irq));
    // ------------------------------
    // Compare, read queue, timeout
    // ------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        core.get(a);
    endtask
    task automatic wrap_up;
        if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) rd_pend <= rd;
    always @(negedge clk) if (rd_pend) chk(rdata, exp_q.pop_front());
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        chk({cal, cal_en, gpio, bci, i1en, i0en, bat, irq}, 8'h20);
        foreach (ofs[i]) rd_chk(ofs[i], (ofs[i] == 8'hF4) ? 8'h60 : 8'h00);
        core.put(8'h00, 8'hFF);
        rd_chk(8'h00, 8'h00);
        for (int i = 5; i < 9; i++) begin
            n = $random(seed);
            core.put(ofs[i], n[7:0]);
            rd_chk(ofs[i], n[7:0]);
        end
        n = $random(seed);
        core.put(8'hC5, n[7:0]);
        rd_chk(8'hC5, n[7:0]);
        core.put(8'hF4, n[15:8]);
        rd_chk(8'hF4, {4'h6, n[11:8]});
        core.put(8'hF4, 8'h00);
        core.put(8'hFF, 8'h8F);
        rd_chk(8'hFF, 8'h00);
        for (int f = 0; f < 16; f++) begin
            core.put_key(8'(f));
            chk({4'h0, gpio, bci, i1en, i0en}, {4'h0, f[2:1] == 2'b00, f[2:1] == 2'b01,
                f[3:2] == 2'b11, f[0]});
            rd_chk(8'hFF, 8'(f));
        end
        core.put(8'hFF, 8'hF0);
        rd_chk(8'hFF, 8'h0F);
        core.put_key(8'hE0);
        @(posedge cal);
        n = 0;
        while (cal === 1'b1 && n < 9000) begin
            @(negedge clk);
            n++;
        end
        chk({7'h0, n >= HALF_3 && n <= HALF_3 + 2}, 8'h01);
        core.put_key(8'h00);
        repeat (3) @(negedge clk);
        chk({6'h0, cal, cal_en}, 8'h00);
        core.put(8'hEC, 8'h20);
        rd_chk(8'hEC, 8'h20);
        for (int i = 0; i < 5; i++) begin
            @(negedge clk);
            ev[i] = 1'b1;
            @(negedge clk);
            ev[i] = 1'b0;
            @(negedge clk);
            chk({7'h0, irq}, {7'h0, i == 0});
            rd_chk(8'hF8, fl[i]);
            core.put(8'hF8, 8'h00);
        end
        rd_chk(8'hF8, 8'h00);
        core.put(8'hEC, 8'h02);
        msl = 1'b1;
        repeat (3) @(negedge clk);
        chk({7'h0, bat}, 8'h01);
        rd_chk(8'hF4, 8'h20);
        rd_chk(8'hF8, 8'h42);
        msl = 1'b0;
        repeat (3) @(negedge clk);
        rd_chk(8'hF4, 8'h60);
        rd_chk(8'hF8, 8'hC2);
        core.put(8'hF8, 8'h00);
        core.put(8'hF5, 8'h01);
        dcl = 1'b1;
        repeat (3) @(negedge clk);
        chk({7'h0, bat}, 8'h01);
        rd_chk(8'hF8, 8'h43);
        dcl = 1'b0;
        n = $random(seed);
        core.put(8'hF5, {6'h00, 1'b1, n[0]});
        rd_chk(8'hF5, {6'h00, 1'b1, n[0]});
        msl = 1'b1;
        repeat (3) @(negedge clk);
        chk({7'h0, bat}, 8'h00);
        msl = 1'b0;
        repeat (3) @(negedge clk);
        wrap_up();
    end
endmodule
